// *** tdc_pkg.sv ***
package tdc_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int CONV_WIDE_NS = 5700;
   localparam int CONV_NARROW_NS = 2800;
   localparam int CONV_WIDE_CYC = CONV_WIDE_NS / CLK_PERIOD_NS;
   localparam int CONV_NARROW_CYC = CONV_NARROW_NS / CLK_PERIOD_NS;
   localparam int CLEAR_NS = 100;
   localparam int CLEAR_CYC = (CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SLOTS = 16;
   localparam int FSR_MIN_NS = 140;
   localparam int FSR_MAX_NS = 1200;
   // ----------------------------------------
   // Threshold memory map and fields
   // ----------------------------------------
   localparam logic [15:0] THR_BASE = 16'h1080;
   localparam logic [15:0] THR_LAST = 16'h10BF;
   localparam logic [15:0] THR_MASK = 16'h01FF;
   localparam int THR_KILL_BIT = 8;
   // ----------------------------------------
   // Data word
   // ----------------------------------------
   localparam int OVF_BIT = 12;
   localparam int BELOW_BIT = 13;
   localparam int INVALID_BIT = 14;
   localparam logic [11:0] SLIDE_MAX = 12'hF00;
   localparam int WORD_W = 16;
   localparam int FIFO_W = 21;
   localparam int FIFO_DEPTH = 16;
endpackage : tdc_pkg

// *** fifo_if.sv ***
`timescale 1ns/10ps
interface fifo_if #(parameter int W = 21);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport sink(input valid, input data, output ready);
   modport source(output valid, output data, input ready);
endinterface : fifo_if

// *** tdc_fifo.sv ***
`timescale 1ns/10ps
module tdc_fifo #(parameter int W = 21, parameter int DEPTH = 16)
(
   input wire logic clk,
   input wire logic rst_n,
   fifo_if.sink wr,
   fifo_if.source rd
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_ff [0:DEPTH-1];
   logic [AW-1:0] wptr_ff;
   logic [AW-1:0] rptr_ff;
   logic [AW:0] count_ff;
   logic do_wr;
   logic do_rd;

   assign wr.ready = (count_ff != (AW+1)'(DEPTH));
   assign rd.valid = (count_ff != '0);
   assign rd.data = mem_ff[rptr_ff];
   assign do_wr = wr.valid && wr.ready;
   assign do_rd = rd.valid && rd.ready;

   always_ff @(posedge clk)
   begin
      if (do_wr)
         mem_ff[wptr_ff] <= wr.data;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wptr_ff <= '0;
         rptr_ff <= '0;
         count_ff <= '0;
      end
      else
      begin
         if (do_wr)
            wptr_ff <= wptr_ff + 1'b1;
         if (do_rd)
            rptr_ff <= rptr_ff + 1'b1;
         if (do_wr && !do_rd)
            count_ff <= count_ff + 1'b1;
         else if (do_rd && !do_wr)
            count_ff <= count_ff - 1'b1;
      end
   end
endmodule : tdc_fifo

// *** tdc_conversion_zero_suppression.sv ***
`timescale 1ns/10ps
module tdc_conversion_zero_suppression
   import tdc_pkg::*;
#(parameter bit NARROW = 1'b0)
(
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic SHARED_TIMING_INPUT,
   input wire logic STOP_MODE_SEL,
   input wire logic SLIDE_EN,
   input wire logic BELOW_LEVEL_KEEP,
   input wire logic LEVEL_GRANULARITY_SEL,
   input wire logic OVERFLOW_KEEP,
   input wire logic VALID_KEEP,
   input wire logic [7:0] FSR_CODE,
   input wire logic [11:0] ADC_A_DATA,
   input wire logic [11:0] ADC_B_DATA,
   input wire logic ADC_A_OVF,
   input wire logic ADC_B_OVF,
   input wire logic ADC_A_INVALID,
   input wire logic ADC_B_INVALID,
   input wire logic [15:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [15:0] REG_WDATA,
   input wire logic DATA_READY,
   output logic [15:0] REG_RDATA,
   output logic STOP_MODE,
   output logic [7:0] FSR_LEVEL,
   output logic [1:0] MUX_GROUP,
   output logic [1:0] MUX_CHAN,
   output logic ADC_SAMPLE,
   output logic [7:0] SLIDE_LEVEL,
   output logic RAMP_DISCHARGE_SWITCH,
   output logic BUSY,
   output logic DATA_VALID,
   output logic [15:0] DATA_WORD,
   output logic [4:0] DATA_CHAN
);
   // ----------------------------------------
   // Constants and state
   // ----------------------------------------
   localparam int CONV_CYC = NARROW ? CONV_NARROW_CYC : CONV_WIDE_CYC;
   localparam int SLOT_CYC = CONV_CYC / SLOTS;

   typedef enum logic [1:0] {S_IDLE, S_CONVERT, S_CLEAR} state_type;

   state_type state_ff;
   state_type nxt_state;
   logic [8:0] cycle_ff;
   logic [3:0] slot_ff;
   logic [4:0] slot_tmr_ff;
   logic slots_done_ff;
   logic [1:0] pend_ff;
   logic [FIFO_W-1:0] word_a_ff;
   logic [FIFO_W-1:0] word_b_ff;
   logic [2:0] clear_tmr_ff;
   logic [7:0] slide_ff;
   logic stop_mode_ff;
   logic [7:0] fsr_ff;
   logic sample_ff;
   logic discharge_ff;
   logic [15:0] rdata_ff;
   logic [15:0] thr_mem [0:31];
   logic thr_hit;
   logic [4:0] thr_idx;
   logic slot_end;
   logic conv_end;
   logic [16:0] judge_a;
   logic [16:0] judge_b;

   fifo_if #(.W(FIFO_W)) push_if();
   fifo_if #(.W(FIFO_W)) pop_if();

   // ----------------------------------------
   // Suppression judgement
   // ----------------------------------------
   // Returns keep flag above the 16-bit data word
   function automatic logic [16:0] judge(input logic [11:0] raw, input logic ovf_in,
                                         input logic inv_in, input logic [15:0] thr);
      logic [12:0] diff;
      logic [11:0] val;
      logic ovf;
      logic below;
      logic inv;
      logic keep;
      logic [15:0] w;
      diff = {1'b0, raw} - {5'h00, slide_ff};
      if (SLIDE_EN)
      begin
         val = diff[11:0];
         ovf = ovf_in | diff[12] | (diff[11:0] > SLIDE_MAX);
      end
      else
      begin
         val = raw;
         ovf = ovf_in;
      end
      if (LEVEL_GRANULARITY_SEL)
         below = (val[8:1] < thr[7:0]) && (val[11:9] == 3'h0);
      else
         below = (val[11:4] < thr[7:0]);
      inv = inv_in & stop_mode_ff;
      // Every check must permit the store
      keep = !thr[THR_KILL_BIT]
             && (!below || BELOW_LEVEL_KEEP)
             && (!ovf || OVERFLOW_KEEP)
             && (!inv || VALID_KEEP);
      w = 16'h0000;
      w[11:0] = val;
      w[OVF_BIT] = ovf;
      w[BELOW_BIT] = below;
      w[INVALID_BIT] = inv;
      return {keep, w};
   endfunction : judge

   assign judge_a = judge(ADC_A_DATA, ADC_A_OVF, ADC_A_INVALID, thr_mem[{1'b0, slot_ff}]);
   assign judge_b = judge(ADC_B_DATA, ADC_B_OVF, ADC_B_INVALID, thr_mem[{1'b1, slot_ff}]);

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // Slot stalls while results wait for the buffer, so the fixed time may stretch under back-pressure
   assign slot_end = (state_ff == S_CONVERT) && !slots_done_ff && (pend_ff == 2'b00)
                     && (slot_tmr_ff == 5'(SLOT_CYC - 1));
   assign conv_end = (state_ff == S_CONVERT) && slots_done_ff && (pend_ff == 2'b00)
                     && (cycle_ff == 9'(CONV_CYC - 1));

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         S_IDLE:
            if (SHARED_TIMING_INPUT)
               nxt_state = S_CONVERT;
         S_CONVERT:
            if (conv_end)
               nxt_state = S_CLEAR;
         S_CLEAR:
            if (clear_tmr_ff == 3'(CLEAR_CYC - 1))
               nxt_state = S_IDLE;
         default:
            nxt_state = S_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         state_ff <= S_IDLE;
      else
         state_ff <= nxt_state;
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         cycle_ff <= 9'h000;
      else if (state_ff != S_CONVERT)
         cycle_ff <= 9'h000;
      else if (cycle_ff != 9'(CONV_CYC - 1))
         cycle_ff <= cycle_ff + 9'h001;
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         slot_ff <= 4'h0;
         slot_tmr_ff <= 5'h00;
         slots_done_ff <= 1'b0;
      end
      else if (state_ff != S_CONVERT)
      begin
         slot_ff <= 4'h0;
         slot_tmr_ff <= 5'h00;
         slots_done_ff <= 1'b0;
      end
      else if (slot_end)
      begin
         slot_ff <= slot_ff + 4'h1;
         slot_tmr_ff <= 5'h00;
         slots_done_ff <= (slot_ff == 4'hF);
      end
      else if (!slots_done_ff && slot_tmr_ff != 5'(SLOT_CYC - 1))
         slot_tmr_ff <= slot_tmr_ff + 5'h01;
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         sample_ff <= 1'b0;
      else
         sample_ff <= (state_ff == S_CONVERT) && !slots_done_ff && (slot_tmr_ff == 5'h00);
   end

   // ----------------------------------------
   // Ramp discharge
   // ----------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         clear_tmr_ff <= 3'h0;
         discharge_ff <= 1'b0;
      end
      else
      begin
         clear_tmr_ff <= (state_ff == S_CLEAR) ? clear_tmr_ff + 3'h1 : 3'h0;
         discharge_ff <= (nxt_state == S_CLEAR);
      end
   end

   // ----------------------------------------
   // Mode, range and sliding offset
   // ----------------------------------------
   // Mode and range only follow while idle so a conversion never sees them change
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         stop_mode_ff <= 1'b0;
         fsr_ff <= 8'h00;
      end
      else if (state_ff == S_IDLE)
      begin
         stop_mode_ff <= STOP_MODE_SEL;
         fsr_ff <= FSR_CODE;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         slide_ff <= 8'h00;
      else if (!SLIDE_EN)
         slide_ff <= 8'h00;
      else if (conv_end)
         slide_ff <= slide_ff + 8'h01;
   end

   // ----------------------------------------
   // Result staging toward the buffer
   // ----------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         pend_ff <= 2'b00;
         word_a_ff <= '0;
         word_b_ff <= '0;
      end
      else if (slot_end)
      begin
         pend_ff <= {judge_b[16] & !NARROW, judge_a[16]};
         word_a_ff <= {1'b0, slot_ff, judge_a[15:0]};
         word_b_ff <= {1'b1, slot_ff, judge_b[15:0]};
      end
      else if (push_if.ready)
      begin
         if (pend_ff[0])
            pend_ff[0] <= 1'b0;
         else
            pend_ff[1] <= 1'b0;
      end
   end

   assign push_if.valid = |pend_ff;
   assign push_if.data = pend_ff[0] ? word_a_ff : word_b_ff;

   tdc_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .wr(push_if),
      .rd(pop_if)
   );

   assign pop_if.ready = DATA_READY;

   // ----------------------------------------
   // Threshold memory
   // ----------------------------------------
   assign thr_hit = (REG_ADDR >= THR_BASE) && (REG_ADDR <= THR_LAST);
   assign thr_idx = REG_ADDR[5:1];

   // No reset term: contents persist through every reset
   always_ff @(posedge CLK_SYS)
   begin
      if (REG_WR && thr_hit)
         thr_mem[thr_idx] <= REG_WDATA & THR_MASK;
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         rdata_ff <= 16'h0000;
      else if (REG_RD)
         rdata_ff <= thr_hit ? thr_mem[thr_idx] : 16'h0000;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign REG_RDATA = rdata_ff;
   assign STOP_MODE = stop_mode_ff;
   assign FSR_LEVEL = fsr_ff;
   assign MUX_GROUP = slot_ff[3:2];
   assign MUX_CHAN = slot_ff[1:0];
   assign ADC_SAMPLE = sample_ff;
   assign SLIDE_LEVEL = slide_ff;
   assign RAMP_DISCHARGE_SWITCH = discharge_ff;
   assign BUSY = (state_ff != S_IDLE);
   assign DATA_VALID = pop_if.valid;
   assign DATA_WORD = pop_if.data[15:0];
   assign DATA_CHAN = pop_if.data[20:16];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_N);

   a_discharge_length: assert property ($rose(discharge_ff) |-> discharge_ff[*5] ##1 !discharge_ff)
      else $error("discharge pulse length wrong");
   a_discharge_quiet: assert property ((state_ff == S_CONVERT) |-> !discharge_ff)
      else $error("discharge during conversion");
   a_conv_fixed: assert property ((state_ff == S_IDLE && nxt_state == S_CONVERT) |-> ##CONV_CYC (state_ff == S_CONVERT))
      else $error("conversion ended early");
   a_kill_blocks: assert property (push_if.valid |-> !thr_mem[push_if.data[20:16]][THR_KILL_BIT])
      else $error("killed channel stored");
   a_below_drop: assert property (push_if.valid && !BELOW_LEVEL_KEEP |-> !push_if.data[BELOW_BIT])
      else $error("below-level datum stored");
   a_overflow_drop: assert property (push_if.valid && !OVERFLOW_KEEP |-> !push_if.data[OVF_BIT])
      else $error("overflow datum stored");
   a_invalid_drop: assert property (push_if.valid && !VALID_KEEP |-> !push_if.data[INVALID_BIT])
      else $error("invalid datum stored");
   a_slide_range: assert property (push_if.valid && SLIDE_EN && !push_if.data[OVF_BIT]
                                   |-> push_if.data[11:0] <= SLIDE_MAX)
      else $error("corrected value out of range");
   a_invalid_mode: assert property (push_if.valid && push_if.data[INVALID_BIT] |-> stop_mode_ff)
      else $error("invalid flag outside stop mode");
endmodule : tdc_conversion_zero_suppression

// *** tdc_front_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Ramp sections and converter pair
// ----------------------------------------
module tdc_front_model
   import tdc_pkg::*;
(
   input wire logic clk,
   input wire logic [1:0] mux_group,
   input wire logic [1:0] mux_chan,
   input wire logic [7:0] slide_level,
   input wire logic discharge,
   input wire logic [11:0] base,
   input wire logic ovf,
   input wire logic inv,
   output logic [11:0] a_data,
   output logic [11:0] b_data,
   output logic ovf_out,
   output logic inv_out,
   output int clears
);
   logic [11:0] level;
   // Level tracks the channel so a wrong mux pick shows
   assign level = base + 12'({mux_group, mux_chan}) + 12'(slide_level);
   assign a_data = level;
   assign b_data = level + 12'h010;
   assign ovf_out = ovf;
   assign inv_out = inv;
   // Cycles the ramp capacitor is shorted
   always_ff @(posedge clk)
   begin
      if (discharge)
      begin
         clears <= clears + 1;
      end
   end
endmodule : tdc_front_model

// *** tdc_conversion_zero_suppression_bench.sv ***
`timescale 1ns/10ps
module tdc_conversion_zero_suppression_bench
   import tdc_pkg::*;
;
   typedef struct {logic gran, bkeep, okeep, vkeep, slide, stop, ovf, inv, kill;
                   logic [7:0] thr; logic [11:0] base;} row_type;
   logic clk_sys = 1'b0, rst_n = 1'b0, start = 1'b0, stop_sel = 1'b0, slide_en = 1'b0;
   logic bkeep = 1'b0, gran = 1'b0, okeep = 1'b0, vkeep = 1'b0, wr = 1'b0, rd = 1'b0, ready = 1'b1;
   logic [7:0] fsr = 8'h00;
   logic [15:0] addr = 16'h0000, wdata = 16'h0000;
   logic [11:0] base = 12'h000, a_data, b_data;
   logic ovf = 1'b0, inv = 1'b0, ovf_out, inv_out;
   logic [15:0] rdata, dword;
   logic stop_mode, ramp_sw, busy, dv, adc_sample;
   logic [7:0] fsr_level, slide_level;
   logic [1:0] mux_group, mux_chan;
   logic [4:0] dchan;
   logic [20:0] got_q[$], exp_q[$];
   int clears, errors = 0, checks_done = 0, cycles = 0, base_cyc = 0, samples = 0;
   // ----------------------------------------
   // Ordinary cases
   // ----------------------------------------
   row_type rows[12] = '{
      '{0,0,0,0,0,0,0,0,0,8'h10,12'h0F0},
      '{0,1,0,0,0,0,0,0,0,8'h10,12'h0F0},
      '{1,0,0,0,0,0,0,0,0,8'h80,12'h0F0},
      '{1,0,0,0,0,0,0,0,0,8'hFF,12'h200},
      '{0,0,0,0,0,0,0,0,1,8'h00,12'h400},
      '{0,0,0,0,0,0,1,0,0,8'h00,12'h800},
      '{0,0,1,0,0,0,1,0,1,8'h00,12'h800},
      '{0,0,0,0,0,1,0,1,0,8'h00,12'h123},
      '{0,0,0,1,0,1,0,1,0,8'h00,12'h123},
      '{0,0,0,0,0,0,0,1,0,8'h00,12'h123},
      '{0,0,0,0,1,0,0,0,0,8'h00,12'hEF0},
      '{0,0,1,0,1,0,0,0,0,8'h00,12'hEF0}
   };

   always #10 clk_sys = ~clk_sys;

   tdc_conversion_zero_suppression i_tdc_conversion_zero_suppression (.CLK_SYS(clk_sys), .RST_N(rst_n),
      .SHARED_TIMING_INPUT(start), .STOP_MODE_SEL(stop_sel), .SLIDE_EN(slide_en), .BELOW_LEVEL_KEEP(bkeep),
      .LEVEL_GRANULARITY_SEL(gran), .OVERFLOW_KEEP(okeep), .VALID_KEEP(vkeep), .FSR_CODE(fsr),
      .ADC_A_DATA(a_data), .ADC_B_DATA(b_data), .ADC_A_OVF(ovf_out), .ADC_B_OVF(ovf_out),
      .ADC_A_INVALID(inv_out), .ADC_B_INVALID(inv_out), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
      .REG_WDATA(wdata), .DATA_READY(ready), .REG_RDATA(rdata), .STOP_MODE(stop_mode), .FSR_LEVEL(fsr_level),
      .MUX_GROUP(mux_group), .MUX_CHAN(mux_chan), .ADC_SAMPLE(adc_sample), .SLIDE_LEVEL(slide_level),
      .RAMP_DISCHARGE_SWITCH(ramp_sw), .BUSY(busy), .DATA_VALID(dv), .DATA_WORD(dword), .DATA_CHAN(dchan));

   tdc_front_model i_tdc_front_model (.clk(clk_sys), .mux_group(mux_group), .mux_chan(mux_chan),
      .slide_level(slide_level), .discharge(ramp_sw), .base(base), .ovf(ovf), .inv(inv), .a_data(a_data),
      .b_data(b_data), .ovf_out(ovf_out), .inv_out(inv_out), .clears(clears));

   always @(posedge clk_sys)
   begin
      if (dv === 1'b1 && ready === 1'b1)
         got_q.push_back({dchan, dword});
      if (adc_sample === 1'b1)
         samples++;
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         summarize();
      end
   end

   task automatic summarize();
      $display("errors %0d checks_done %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask : tick

   // Leaves the write strobe up so back-to-back writes never toggle it
   task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      tick(1);
   endtask : reg_write

   task automatic reg_read(input logic [15:0] a, input logic [15:0] exp);
      wr = 1'b0;
      addr = a;
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      tick(1);
      chk(32'(rdata), 32'(exp), "register read");
   endtask : reg_read

   // ----------------------------------------
   // One conversion with expected stream
   // ----------------------------------------
   task automatic run_row(input row_type r, input bit stall);
      logic [11:0] v;
      logic [4:0] ch;
      logic below, o, iv;
      int cyc;
      int clr;
      int smp;
      logic [7:0] sld;
      for (int i = 0; i < 32; i++)
         reg_write(THR_BASE + 16'(2 * i), {7'h00, r.kill & i[0], r.thr});
      wr = 1'b0;
      {gran, bkeep, okeep, vkeep} = {r.gran, r.bkeep, r.okeep, r.vkeep};
      {slide_en, stop_sel, ovf, inv} = {r.slide, r.stop, r.ovf, r.inv};
      base = r.base;
      fsr = {8{r.thr[0] | r.ovf}};
      exp_q.delete();
      got_q.delete();
      for (int i = 0; i < 32; i++)
      begin
         ch = i[0] ? 5'(16 + i / 2) : 5'(i / 2);
         v = r.base + 12'(ch);
         o = r.ovf | (r.slide & (v > SLIDE_MAX));
         below = r.gran ? (v[8:1] < r.thr && v[11:9] == 3'h0) : (v[11:4] < r.thr);
         iv = r.inv & r.stop;
         if (!(r.kill & ch[0]) && (!below || r.bkeep) && (!o || r.okeep) && (!iv || r.vkeep))
            exp_q.push_back({ch, 1'b0, iv, below, o, v});
      end
      ready = !stall;
      clr = clears;
      smp = samples;
      sld = slide_level;
      start = 1'b1;
      // Start held on while busy must not launch a second pass
      tick(5);
      start = 1'b0;
      cyc = 5;
      if (stall)
      begin
         tick(700);
         chk(32'({busy, dv}), 32'h3, "stalled on full buffer");
         ready = 1'b1;
      end
      while (busy !== 1'b0 && cyc < 3000)
      begin
         tick(1);
         cyc++;
      end
      for (int n = 0; n < 100 && dv !== 1'b0; n++)
         tick(1);
      chk(32'(clears - clr), 32'(CLEAR_CYC), "discharge length");
      chk(32'(samples - smp), 32'(SLOTS), "sample pulses");
      chk(32'(slide_level), r.slide ? 32'(8'(sld + 8'h01)) : 32'h0, "sliding offset");
      chk(32'(stop_mode), 32'(r.stop), "mode");
      chk(32'(fsr_level), 32'(fsr), "range code");
      chk(32'(got_q.size()), 32'(exp_q.size()), "stored count");
      foreach (exp_q[i])
         if (i < got_q.size())
            chk(32'(got_q[i]), 32'(exp_q[i]), "stored word");
      if (!stall && base_cyc == 0)
         base_cyc = cyc;
      else if (!stall)
         chk(32'(cyc), 32'(base_cyc), "conversion time");
   endtask : run_row

   initial
   begin
      tick(6);
      chk(32'({busy, dv, ramp_sw}), 32'h0, "outputs in reset");
      rst_n = 1'b1;
      tick(1);
      foreach (rows[i])
         run_row(rows[i], 1'b0);
      chk(32'(base_cyc >= CONV_WIDE_CYC && base_cyc <= CONV_WIDE_CYC + CLEAR_CYC + 8), 32'h1, "time bound");
      // ----------------------------------------
      // Awkward cases
      // ----------------------------------------
      run_row(rows[1], 1'b1);
      reg_write(16'h1082, 16'hFFFF);
      reg_read(16'h1082, THR_MASK);
      reg_write(16'h107E, 16'h00AA);
      reg_read(16'h107E, 16'h0000);
      reg_read(THR_LAST + 16'h0001, 16'h0000);
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      tick(1);
      reg_read(16'h1082, THR_MASK);
      summarize();
   end
endmodule : tdc_conversion_zero_suppression_bench
